// file: logic/upeq_pkg.sv
// constants for the usb3 phy equalizer override register pair
// Operation
// - override on for port 4: equalizer init from bits 31:28, functional from 27:24
// - override on for port 3: equalizer init from bits 23:20, functional from 19:16
// - override on for port 2: equalizer init from bits 15:12, functional from 11:8
// - override on for port 1: equalizer init from bits 7:4, functional from 3:0
// - two-port build: port 3 and 4 fields never reach any phy
// - equalizer fields cleared by pcie reset, global reset and power-on reset
// - control register holds per-port de-emphasis, swing and equalizer override enables
// - control register is read/write at ech and resets to zero
// - equalizer override enables sit at bits 26, 18, 10 and 2
// - reserved control bits such as 31:27 always read zero
package upeq_pkg;
    localparam int NPORTS = 4;
    localparam int FIELD_W = 4;
    localparam int PORT_STRIDE = 8;
    localparam int INIT_LSB = 4;
    localparam int FUNC_LSB = 0;
    localparam int EQ_OV_BIT = 2;
    localparam int SWING_OV_BIT = 1;
    localparam int DE_OV_BIT = 0;
    localparam int BYTE_W = 8;
    localparam int NBYTES = 4;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] OFS_EQ_VALUES = 12'h0e8;
    localparam logic [ADDR_W-1:0] OFS_OVERRIDE = 12'h0ec;
    localparam logic [DATA_W-1:0] EQ_VALUES_RESET = 32'h0000_0000;
    localparam logic [DATA_W-1:0] OVERRIDE_RESET = 32'h0000_0000;
    localparam logic [DATA_W-1:0] EQ_VALUES_MASK = 32'hffff_ffff;
    localparam logic [DATA_W-1:0] OVERRIDE_MASK = 32'h0707_0707;
    localparam logic [DATA_W-1:0] UNMAPPED_DATA = 32'h0000_0000;
    // phy internal defaults used while no override is active
    localparam logic [FIELD_W-1:0] DEF_EQ_INIT = 4'h7;
    localparam logic [FIELD_W-1:0] DEF_EQ_FUNC = 4'h3;
endpackage

// file: logic/upeq_port_if.sv
// per-port bundle between the register bank and the equalizer selector
`timescale 1ns/100ps
interface upeq_port_if;
    logic present;
    logic override;
    logic [upeq_pkg::FIELD_W-1:0] init_fld;
    logic [upeq_pkg::FIELD_W-1:0] func_fld;
    modport ctl (output present, output override, output init_fld, output func_fld);
    modport sel (input present, input override, input init_fld, input func_fld);
endinterface

// file: logic/upeq_port_sel.sv
// registered equalizer source selector for one phy port
`timescale 1ns/100ps
module upeq_port_sel (
    input wire logic ref_clk, // 40 MHz clock
    input wire logic clr, // any reset source, sync active high
    input wire logic ce, // clock enable, freezes state when low
    upeq_port_if.sel port, // fields and enable for this port
    output logic [upeq_pkg::FIELD_W-1:0] eq_init, // equalizer init value to phy
    output logic [upeq_pkg::FIELD_W-1:0] eq_func // equalizer functional value to phy
);
    logic use_fld;

    // an absent port never takes programmed values
    assign use_fld = port.present && port.override;

    always_ff @(posedge ref_clk) begin
        if (ce) begin
            if (clr) begin
                eq_init <= upeq_pkg::DEF_EQ_INIT;
                eq_func <= upeq_pkg::DEF_EQ_FUNC;
            end else if (use_fld) begin
                eq_init <= port.init_fld;
                eq_func <= port.func_fld;
            end else begin
                eq_init <= upeq_pkg::DEF_EQ_INIT;
                eq_func <= upeq_pkg::DEF_EQ_FUNC;
            end
        end
    end

    ov_select_a: assert property (@(posedge ref_clk) disable iff (clr)
        ce && port.present && port.override |=> eq_init == $past(port.init_fld)
            && eq_func == $past(port.func_fld))
        else $error("override did not select programmed fields");
    default_sel_a: assert property (@(posedge ref_clk) disable iff (clr)
        ce && !port.override |=> eq_init == upeq_pkg::DEF_EQ_INIT
            && eq_func == upeq_pkg::DEF_EQ_FUNC)
        else $error("default equalizer not applied with override off");
    absent_port_a: assert property (@(posedge ref_clk) disable iff (clr)
        ce && !port.present |=> eq_init == upeq_pkg::DEF_EQ_INIT
            && eq_func == upeq_pkg::DEF_EQ_FUNC)
        else $error("absent port reached its phy");
    ov_used_c: cover property (@(posedge ref_clk) disable iff (clr)
        ce && port.present && port.override ##1 eq_init != upeq_pkg::DEF_EQ_INIT);
endmodule

// file: logic/upeq_regs.sv
// equalizer value and override enable registers in configuration space
`timescale 1ns/100ps
module upeq_regs #(
    parameter int NUM_PORTS = 4 // 4 or 2 downstream usb3 ports
) (
    input wire logic ref_clk, // 40 MHz clock
    input wire logic rst, // power-on reset, sync active high
    input wire logic ce, // clock enable, freezes state when low
    input wire logic pcie_reset_n, // pcie fundamental reset, sync active low
    input wire logic global_reset_n, // global reset, sync active low
    input wire logic cfg_req, // config access request, one cycle
    input wire logic cfg_we, // 1 write, 0 read
    input wire logic [upeq_pkg::ADDR_W-1:0] cfg_addr, // config byte address
    input wire logic [upeq_pkg::NBYTES-1:0] cfg_be, // byte enables for writes
    input wire logic [upeq_pkg::DATA_W-1:0] cfg_wdata, // write data
    output logic [upeq_pkg::DATA_W-1:0] cfg_rdata, // read data, valid with ack
    output logic cfg_ack, // access done, one cycle after request
    output logic [upeq_pkg::NPORTS*upeq_pkg::FIELD_W-1:0] phy_eq_init, // per-port eq init
    output logic [upeq_pkg::NPORTS*upeq_pkg::FIELD_W-1:0] phy_eq_func, // per-port eq func
    output logic [upeq_pkg::NPORTS-1:0] phy_swing_ov, // per-port swing override enable
    output logic [upeq_pkg::NPORTS-1:0] phy_de_ov // per-port de-emphasis override enable
);
    logic [upeq_pkg::DATA_W-1:0] eq_values;
    logic [upeq_pkg::DATA_W-1:0] override_en;
    logic [upeq_pkg::DATA_W-1:0] next_rdata;
    logic clr;
    logic hit_eq;
    logic hit_ov;

    function automatic logic [upeq_pkg::DATA_W-1:0] upeq_merge(
        input logic [upeq_pkg::DATA_W-1:0] old_val,
        input logic [upeq_pkg::DATA_W-1:0] wd,
        input logic [upeq_pkg::NBYTES-1:0] be,
        input logic [upeq_pkg::DATA_W-1:0] mask
    );
        logic [upeq_pkg::DATA_W-1:0] res;
        res = old_val;
        for (int b = 0; b < upeq_pkg::NBYTES; b++) begin
            if (be[b]) begin
                res[b*upeq_pkg::BYTE_W +: upeq_pkg::BYTE_W] =
                    wd[b*upeq_pkg::BYTE_W +: upeq_pkg::BYTE_W];
            end
        end
        return res & mask;
    endfunction

    // all three reset sources clear both registers
    assign clr = rst || !pcie_reset_n || !global_reset_n;
    // only aligned exact offsets decode, anything else reads zero
    assign hit_eq = cfg_addr == upeq_pkg::OFS_EQ_VALUES;
    assign hit_ov = cfg_addr == upeq_pkg::OFS_OVERRIDE;

    always_ff @(posedge ref_clk) begin
        if (ce) begin
            if (clr) begin
                eq_values <= upeq_pkg::EQ_VALUES_RESET;
            end else if (cfg_req && cfg_we && hit_eq) begin
                eq_values <= upeq_merge(eq_values, cfg_wdata, cfg_be, upeq_pkg::EQ_VALUES_MASK);
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (ce) begin
            if (clr) begin
                override_en <= upeq_pkg::OVERRIDE_RESET;
            end else if (cfg_req && cfg_we && hit_ov) begin
                // reserved bits never store, so they read back zero
                override_en <= upeq_merge(override_en, cfg_wdata, cfg_be,
                    upeq_pkg::OVERRIDE_MASK);
            end
        end
    end

    always_comb begin
        next_rdata = upeq_pkg::UNMAPPED_DATA;
        if (hit_eq) begin
            next_rdata = eq_values;
        end else if (hit_ov) begin
            next_rdata = override_en;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (ce) begin
            if (rst) begin
                cfg_ack <= 1'b0;
                cfg_rdata <= upeq_pkg::UNMAPPED_DATA;
            end else begin
                cfg_ack <= cfg_req;
                if (cfg_req && !cfg_we) begin
                    cfg_rdata <= next_rdata;
                end
            end
        end
    end

    for (genvar i = 0; i < upeq_pkg::NPORTS; i++) begin : g_port
        localparam int BASE = i * upeq_pkg::PORT_STRIDE;
        upeq_port_if port_if ();
        assign port_if.present = i < NUM_PORTS;
        assign port_if.override = override_en[BASE + upeq_pkg::EQ_OV_BIT];
        assign port_if.init_fld = eq_values[BASE + upeq_pkg::INIT_LSB +: upeq_pkg::FIELD_W];
        assign port_if.func_fld = eq_values[BASE + upeq_pkg::FUNC_LSB +: upeq_pkg::FIELD_W];
        assign phy_swing_ov[i] = override_en[BASE + upeq_pkg::SWING_OV_BIT];
        assign phy_de_ov[i] = override_en[BASE + upeq_pkg::DE_OV_BIT];
        upeq_port_sel u_sel (
            .ref_clk (ref_clk),
            .clr (clr),
            .ce (ce),
            .port (port_if.sel),
            .eq_init (phy_eq_init[i*upeq_pkg::FIELD_W +: upeq_pkg::FIELD_W]),
            .eq_func (phy_eq_func[i*upeq_pkg::FIELD_W +: upeq_pkg::FIELD_W])
        );
    end

    eq_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
        ce && clr |=> eq_values == upeq_pkg::EQ_VALUES_RESET
            && override_en == upeq_pkg::OVERRIDE_RESET)
        else $error("reset source did not clear registers");
    rsvd_zero_a: assert property (@(posedge ref_clk) disable iff (rst)
        (override_en & ~upeq_pkg::OVERRIDE_MASK) == 32'h0000_0000)
        else $error("reserved control bit is set");
    ov_readback_a: assert property (@(posedge ref_clk) disable iff (rst)
        ce && cfg_req && !cfg_we && hit_ov |=> cfg_ack && cfg_rdata == $past(override_en))
        else $error("control register read returned wrong data");
    eq_write_a: assert property (@(posedge ref_clk) disable iff (clr)
        ce && cfg_req && cfg_we && hit_eq && cfg_be == 4'hf
            |=> eq_values == $past(cfg_wdata))
        else $error("equalizer register write lost");
    p4_path_a: assert property (@(posedge ref_clk) disable iff (clr)
        ce && override_en[26] && NUM_PORTS == 4
            |=> phy_eq_init[15:12] == $past(eq_values[31:28])
            && phy_eq_func[15:12] == $past(eq_values[27:24]))
        else $error("port 4 override path wrong");
    unmapped_a: assert property (@(posedge ref_clk) disable iff (rst)
        ce && cfg_req && !cfg_we && !hit_eq && !hit_ov |=> cfg_rdata == upeq_pkg::UNMAPPED_DATA)
        else $error("unmapped read not zero");

    ov_write_c: cover property (@(posedge ref_clk) disable iff (rst)
        ce && cfg_req && cfg_we && hit_ov && cfg_wdata[2]);
    eq_read_c: cover property (@(posedge ref_clk) disable iff (rst)
        ce && cfg_req && !cfg_we && hit_eq ##1 cfg_rdata != 32'h0000_0000);
    glob_clr_c: cover property (@(posedge ref_clk) disable iff (rst)
        ce && !global_reset_n && override_en != 32'h0000_0000);
endmodule

// file: testbench/upeq_phy_model.sv
// receiver equalizer model that latches the settings the bank presents
`timescale 1ns/100ps
module upeq_phy_model (
    input wire logic ref_clk, // 40 MHz clock
    input wire logic [15:0] eq_init, // init values from the bank
    input wire logic [15:0] eq_func, // functional values from the bank
    output logic [15:0] seen_init, // init values the receivers run with
    output logic [15:0] seen_func // functional values in use
);
    // receivers pick settings up one cycle late, never combinationally
    always_ff @(posedge ref_clk) begin
        seen_init <= eq_init;
        seen_func <= eq_func;
    end
endmodule

// file: testbench/test_upeq_regs.sv
// self-checking bench for the equalizer override register pair
`timescale 1ns/100ps
module test_upeq_regs;
    logic ref_clk, rst, ce, pcie_reset_n, global_reset_n, cfg_req, cfg_we, cfg_ack;
    logic [11:0] cfg_addr;
    logic [3:0] cfg_be, phy_swing_ov, phy_de_ov;
    logic [31:0] cfg_wdata, cfg_rdata;
    logic [15:0] phy_eq_init, phy_eq_func, init2, func2, seen_init, seen_func;
    bit [31:0] ref_eq, ref_ov, rnd;
    int n_mismatch = 0, check_count = 0;
    upeq_regs #(.NUM_PORTS(4)) upeq_regs_i (.ref_clk(ref_clk), .rst(rst), .ce(ce),
        .pcie_reset_n(pcie_reset_n), .global_reset_n(global_reset_n), .cfg_req(cfg_req),
        .cfg_we(cfg_we), .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
        .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack), .phy_eq_init(phy_eq_init),
        .phy_eq_func(phy_eq_func), .phy_swing_ov(phy_swing_ov), .phy_de_ov(phy_de_ov));
    // two-port build shares every input, only its phy equalizer init and func outputs are watched
    upeq_regs #(.NUM_PORTS(2)) upeq_regs_two_i (.ref_clk(ref_clk), .rst(rst), .ce(ce),
        .pcie_reset_n(pcie_reset_n), .global_reset_n(global_reset_n), .cfg_req(cfg_req),
        .cfg_we(cfg_we), .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
        .cfg_rdata(), .cfg_ack(), .phy_eq_init(init2), .phy_eq_func(func2),
        .phy_swing_ov(), .phy_de_ov());
    upeq_phy_model upeq_phy_model_i (.ref_clk(ref_clk), .eq_init(phy_eq_init),
        .eq_func(phy_eq_func), .seen_init(seen_init), .seen_func(seen_func));
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("FAIL t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    function automatic bit [31:0] merge(input bit [31:0] o, input bit [31:0] w, input bit [3:0] be);
        for (int b = 0; b < 4; b++) if (be[b]) o[8*b+:8] = w[8*b+:8];
        return o;
    endfunction
    function automatic bit [31:0] exp_phy(input int np);
        bit [31:0] r;
        for (int p = 0; p < 4; p++) begin
            r[16+4*p+:4] = (p < np && ref_ov[8*p+2]) ? ref_eq[8*p+4+:4] : 4'h7;
            r[4*p+:4] = (p < np && ref_ov[8*p+2]) ? ref_eq[8*p+:4] : 4'h3;
        end
        return r;
    endfunction
    task automatic access(input logic we, input logic [11:0] a, input logic [3:0] be,
                          input logic [31:0] wd);
        @(posedge ref_clk);
        cfg_req <= 1'b1;
        cfg_we <= we;
        cfg_addr <= a;
        cfg_be <= be;
        cfg_wdata <= wd;
        @(posedge ref_clk);
        cfg_req <= 1'b0;
        #1 check({31'h0, cfg_ack}, 32'h1);
        if (we && a == 12'h0e8) ref_eq = merge(ref_eq, wd, be);
        if (we && a == 12'h0ec) ref_ov = merge(ref_ov, wd, be) & 32'h0707_0707;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        access(1'b0, a, 4'hf, $urandom);
        check(cfg_rdata, exp);
    endtask
    task automatic chk_phy();
        bit [7:0] ov;
        for (int p = 0; p < 4; p++) ov[p+4] = ref_ov[8*p+1];
        for (int p = 0; p < 4; p++) ov[p] = ref_ov[8*p];
        repeat (2) @(posedge ref_clk);
        #1 check({seen_init, seen_func}, exp_phy(4));
        check({init2, func2}, exp_phy(2));
        check({24'h0, phy_swing_ov, phy_de_ov}, {24'h0, ov});
    endtask
    initial begin
        repeat (3000) @(posedge ref_clk);
        n_mismatch++;
        give_verdict();
    end
    initial begin
        {rst, ce, pcie_reset_n, global_reset_n} = 4'hf;
        {cfg_req, cfg_we, cfg_addr, cfg_be, cfg_wdata} = '0;
        rnd = $urandom(32'h55143492);
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        rd(12'h0e8, 32'h0);
        rd(12'h0ec, 32'h0);
        chk_phy();
        access(1'b1, 12'h0ec, 4'hf, 32'hffff_ffff);
        rd(12'h0ec, 32'h0707_0707);
        for (int p = 0; p < 4; p++) begin
            access(1'b1, 12'h0e8, 4'hf, $urandom);
            access(1'b1, 12'h0ec, 4'hf, 32'h4 << (8 * p));
            chk_phy();
        end
        for (int i = 0; i < 10; i++) begin
            access(1'b1, 12'h0e8, 4'(i), $urandom);
            access(1'b1, 12'h0ec, 4'hf, $urandom);
            rd(12'h0e8, ref_eq);
            rd(12'h0ec, ref_ov);
            chk_phy();
        end
        rd(12'h0e4, 32'h0);
        rd(12'h0e9, 32'h0);
        for (int r = 0; r < 2; r++) begin
            access(1'b1, 12'h0e8, 4'hf, $urandom);
            access(1'b1, 12'h0ec, 4'hf, 32'h0404_0404);
            @(posedge ref_clk);
            pcie_reset_n <= (r != 0);
            global_reset_n <= (r == 0);
            @(posedge ref_clk);
            {pcie_reset_n, global_reset_n} <= 2'b11;
            ref_eq = 0;
            ref_ov = 0;
            rd(12'h0e8, 32'h0);
            rd(12'h0ec, 32'h0);
            chk_phy();
        end
        // clock enable low: a request must neither land nor be acked
        @(posedge ref_clk);
        ce <= 1'b0;
        cfg_req <= 1'b1;
        cfg_we <= 1'b1;
        cfg_addr <= 12'h0e8;
        cfg_be <= 4'hf;
        cfg_wdata <= 32'hffff_ffff;
        @(posedge ref_clk);
        cfg_req <= 1'b0;
        #1 check({31'h0, cfg_ack}, 32'h0);
        @(posedge ref_clk);
        ce <= 1'b1;
        rd(12'h0e8, ref_eq);
        chk_phy();
        give_verdict();
    end
endmodule
